// *** rtl/fwpc_top.sv ***
/*
  Write-protection and configuration control of a serial flash: SPI
  command decode, status and configuration bits, protect decode, busy.
  Assumes an SPI mode 0/3 master, sck at most ref_clk/8, and cellInit
  pulsed once before use to seed the non-volatile cells.
*/
`timescale 1ns/1ns
`default_nettype none
module fwpc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cellInit,
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic wpN,
  output logic so,
  output logic soOe,
  output logic powerActive,
  output logic deepPowerDown,
  output logic writeInProgress,
  output logic opStart,
  output logic [fwpc_pkg::KIND_W-1:0] opKind,
  output logic [fwpc_pkg::ADDR_W-1:0] opAddr
);
  import fwpc_pkg::*;

  logic [3:0] pinQ;
  logic sckQ, csQ, siQ, wpQ;
  fwpc_prot_if pi ();

  fwpc_sync #(.W(4), .INIT(PIN_INIT)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({sck, csN, si, wpN}),
    .q(pinQ)
  );
  assign {sckQ, csQ, siQ, wpQ} = pinQ;

  fwpc_range u_range (
    .pi(pi)
  );

  fwpc_state_e state_r, state_nxt;
  logic sckPrev_r, sckPrev_nxt, csPrev_r, csPrev_nxt;
  logic [31:0] shift_r, shift_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [2:0] mod_r, mod_nxt;
  logic [7:0] op_r, op_nxt, outSh_r, outSh_nxt;
  logic outAct_r, outAct_nxt, so_r, so_nxt, soOe_r, soOe_nxt;
  logic wel_r, wel_nxt, lock_r, lock_nxt, pFail_r, pFail_nxt, eFail_r, eFail_nxt;
  logic [2:0] bpV_r, bpV_nxt;
  logic [BUSY_W-1:0] busy_r, busy_nxt;
  logic opStart_r, opStart_nxt;
  logic [KIND_W-1:0] opKind_r, opKind_nxt;
  logic [ADDR_W-1:0] opAddr_r, opAddr_nxt;
  logic active_r, active_nxt, dpd_r, dpd_nxt, wip_r, wip_nxt;
  // non-volatile cells: untouched by rst, seeded by cellInit
  logic status_write_disable_r, status_write_disable_nxt, quad_r, quad_nxt, pTop_r, pTop_nxt;
  logic bpVol_r, bpVol_nxt, fromBot_r, fromBot_nxt;
  logic [2:0] block_protect_volatile_r, block_protect_volatile_nxt;
  logic sckRise, sckFall, csRise, frameOk, wpEff, hwProt, inParam, launch;
  logic [2:0] bpEff;
  logic [KIND_W-1:0] kind;
  logic [7:0] statusByte, configByte, st, cf;
  logic [5:0] sector;

  assign sector = shift_r[SECT_MSB:SECT_LSB];
  assign pi.bp = bpEff;
  assign pi.fromBottom = fromBot_r;
  assign pi.sector = sector;

  always_comb begin
    state_nxt = state_r;
    sckPrev_nxt = sckQ;
    csPrev_nxt = csQ;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    mod_nxt = mod_r;
    op_nxt = op_r;
    outSh_nxt = outSh_r;
    outAct_nxt = outAct_r;
    so_nxt = so_r;
    wel_nxt = wel_r;
    lock_nxt = lock_r;
    pFail_nxt = pFail_r;
    eFail_nxt = eFail_r;
    bpV_nxt = bpV_r;
    busy_nxt = busy_r;
    opStart_nxt = 1'b0;
    opKind_nxt = opKind_r;
    opAddr_nxt = opAddr_r;
    status_write_disable_nxt = status_write_disable_r;
    quad_nxt = quad_r;
    pTop_nxt = pTop_r;
    bpVol_nxt = bpVol_r;
    fromBot_nxt = fromBot_r;
    block_protect_volatile_nxt = block_protect_volatile_r;
    launch = 1'b0;
    kind = KIND_PROG;
    sckRise = sckQ & ~sckPrev_r;
    sckFall = ~sckQ & sckPrev_r;
    csRise = csQ & ~csPrev_r;
    wpEff = quad_r | wpQ;
    hwProt = status_write_disable_r & ~wpEff;
    bpEff = bpVol_r ? bpV_r : block_protect_volatile_r;
    inParam = pTop_r ? (sector >= PARAM_TOP_FIRST) : (sector <= PARAM_BOT_LAST);
    frameOk = (mod_r == 3'h0) && (cnt_r >= CNT_OPCODE);
    statusByte = '0;
    statusByte[SB_WIP] = (state_r == S_BUSY);
    statusByte[SB_WEL] = wel_r;
    statusByte[SB_BP +: 3] = bpEff;
    statusByte[SB_EFAIL] = eFail_r;
    statusByte[SB_PFAIL] = pFail_r;
    statusByte[SB_STATUS_WRITE_DISABLE] = status_write_disable_r;
    // bits 7, 6 and 4 stay zero whatever was written
    configByte = '0;
    configByte[CB_LOCK] = lock_r;
    configByte[CB_QUAD] = quad_r;
    configByte[CB_PTOP] = pTop_r;
    configByte[CB_BPVOL] = bpVol_r;
    configByte[CB_FROMBOT] = fromBot_r;
    st = (cnt_r == CNT_STATUS) ? shift_r[7:0] : shift_r[15:8];
    cf = shift_r[7:0];

    if (!csQ) begin
      if (sckRise) begin
        // only the first 32 bits are kept; later bits are just counted
        if (cnt_r < CNT_ADDR) begin
          shift_nxt = {shift_r[30:0], siQ};
        end
        if (cnt_r < CNT_SAT) begin
          cnt_nxt = cnt_r + 6'h01;
        end
        mod_nxt = mod_r + 3'h1;
        if (cnt_r == CNT_OPCODE - 6'h01) begin
          op_nxt = {shift_r[6:0], siQ};
          if (state_r != S_DEEP && op_nxt == CMD_RDSR) begin
            outSh_nxt = statusByte;
            outAct_nxt = 1'b1;
          end else if (state_r != S_DEEP && op_nxt == CMD_RDCR) begin
            outSh_nxt = configByte;
            outAct_nxt = 1'b1;
          end
        end
      end
      if (sckFall && outAct_r) begin
        so_nxt = outSh_r[7];
        outSh_nxt = {outSh_r[6:0], outSh_r[7]};
      end
    end
    if (csRise) begin
      cnt_nxt = '0;
      mod_nxt = '0;
      outAct_nxt = 1'b0;
    end

    case (state_r)
      S_BUSY: begin
        if (busy_r == '0) begin
          state_nxt = S_READY;
          wel_nxt = 1'b0;
        end else begin
          busy_nxt = busy_r - 1'b1;
        end
      end
      S_DEEP: begin
        // only the wake command is heard
        if (csRise && frameOk && op_r == CMD_WAKE) begin
          state_nxt = S_READY;
        end
      end
      S_READY: begin
        if (csRise && frameOk) begin
          case (op_r)
            CMD_WRITE_ENABLE_CMD: wel_nxt = 1'b1;
            CMD_WRITE_DISABLE_CMD: wel_nxt = 1'b0;
            CMD_DEEP: state_nxt = S_DEEP;
            CMD_REGW: begin
              if (wel_r && (cnt_r == CNT_STATUS || cnt_r == CNT_CONFIG)) begin
                launch = 1'b1;
                kind = KIND_REG;
                if (!hwProt) begin
                  status_write_disable_nxt = st[SB_STATUS_WRITE_DISABLE];
                  if (!lock_r) begin
                    if (bpVol_r) begin
                      bpV_nxt = st[SB_BP +: 3];
                    end else begin
                      block_protect_volatile_nxt = st[SB_BP +: 3];
                    end
                  end
                end
                if (cnt_r == CNT_CONFIG && !lock_r) begin
                  lock_nxt = cf[CB_LOCK];
                  quad_nxt = cf[CB_QUAD];
                  pTop_nxt = pTop_r | cf[CB_PTOP];
                  bpVol_nxt = bpVol_r | cf[CB_BPVOL];
                  fromBot_nxt = fromBot_r | cf[CB_FROMBOT];
                end
              end
            end
            CMD_PROG, CMD_QPROG: begin
              if (wel_r && cnt_r >= CNT_ADDR) begin
                pFail_nxt = pi.hit;
                launch = ~pi.hit;
              end
            end
            CMD_OTP: begin
              if (wel_r && cnt_r >= CNT_ADDR) begin
                pFail_nxt = 1'b0;
                launch = 1'b1;
                kind = KIND_OTP;
              end
            end
            CMD_E64, CMD_E4, CMD_E8: begin
              if (wel_r && cnt_r >= CNT_ADDR) begin
                // small erases only land inside the parameter sectors
                eFail_nxt = pi.hit | (op_r != CMD_E64 && !inParam);
                launch = ~eFail_nxt;
                kind = (op_r == CMD_E64) ? KIND_E64 : (op_r == CMD_E4) ? KIND_E4 : KIND_E8;
              end
            end
            CMD_BULK: begin
              if (wel_r) begin
                eFail_nxt = (bpEff != BP_NONE);
                launch = ~eFail_nxt;
                kind = KIND_BULK;
              end
            end
            default: ;
          endcase
        end
      end
      default: state_nxt = S_READY;
    endcase

    if (launch) begin
      state_nxt = S_BUSY;
      busy_nxt = OP_LAST;
      opStart_nxt = 1'b1;
      opKind_nxt = kind;
      opAddr_nxt = shift_r[ADDR_W-1:0];
    end
    if (cellInit) begin
      status_write_disable_nxt = NV_FLAG_INIT;
      quad_nxt = NV_FLAG_INIT;
      pTop_nxt = NV_FLAG_INIT;
      bpVol_nxt = NV_FLAG_INIT;
      fromBot_nxt = NV_FLAG_INIT;
      block_protect_volatile_nxt = NV_BP_INIT;
    end
    soOe_nxt = outAct_nxt & ~csQ;
    active_nxt = ~csQ | (state_nxt == S_BUSY);
    dpd_nxt = (state_nxt == S_DEEP);
    wip_nxt = (state_nxt == S_BUSY);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= S_READY;
      sckPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
      shift_r <= '0;
      cnt_r <= '0;
      mod_r <= '0;
      op_r <= '0;
      outSh_r <= '0;
      outAct_r <= 1'b0;
      so_r <= 1'b0;
      soOe_r <= 1'b0;
      wel_r <= 1'b0;
      lock_r <= 1'b0;
      pFail_r <= 1'b0;
      eFail_r <= 1'b0;
      bpV_r <= BP_VOL_RESET;
      busy_r <= '0;
      opStart_r <= 1'b0;
      opKind_r <= '0;
      opAddr_r <= '0;
      active_r <= 1'b0;
      dpd_r <= 1'b0;
      wip_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sckPrev_r <= sckPrev_nxt;
      csPrev_r <= csPrev_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      mod_r <= mod_nxt;
      op_r <= op_nxt;
      outSh_r <= outSh_nxt;
      outAct_r <= outAct_nxt;
      so_r <= so_nxt;
      soOe_r <= soOe_nxt;
      wel_r <= wel_nxt;
      lock_r <= lock_nxt;
      pFail_r <= pFail_nxt;
      eFail_r <= eFail_nxt;
      bpV_r <= bpV_nxt;
      busy_r <= busy_nxt;
      opStart_r <= opStart_nxt;
      opKind_r <= opKind_nxt;
      opAddr_r <= opAddr_nxt;
      active_r <= active_nxt;
      dpd_r <= dpd_nxt;
      wip_r <= wip_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    status_write_disable_r <= status_write_disable_nxt;
    quad_r <= quad_nxt;
    pTop_r <= pTop_nxt;
    bpVol_r <= bpVol_nxt;
    fromBot_r <= fromBot_nxt;
    block_protect_volatile_r <= block_protect_volatile_nxt;
  end

  assign so = so_r;
  assign soOe = soOe_r;
  assign powerActive = active_r;
  assign deepPowerDown = dpd_r;
  assign writeInProgress = wip_r;
  assign opStart = opStart_r;
  assign opKind = opKind_r;
  assign opAddr = opAddr_r;

  property p_active;
    @(posedge ref_clk) disable iff (rst) !csQ |=> active_r;
  endproperty
  a_active: assert property (p_active)
    else $error("selected device not active");
  property p_deep;
    @(posedge ref_clk) disable iff (rst) dpd_r ##1 dpd_r |-> !opStart_r;
  endproperty
  a_deep: assert property (p_deep)
    else $error("operation started in deep power-down");
  property p_wip;
    @(posedge ref_clk) disable iff (rst) opStart_r |-> wip_r[*8];
  endproperty
  a_wip: assert property (p_wip)
    else $error("busy flag dropped early");
  property p_hwprot;
    @(posedge ref_clk) disable iff (rst || cellInit) hwProt |=> $stable({status_write_disable_r, block_protect_volatile_r});
  endproperty
  a_hwprot: assert property (p_hwprot)
    else $error("status changed under hardware protection");
  property p_lock;
    @(posedge ref_clk) disable iff (rst || cellInit)
      lock_r |=> lock_r && $stable({bpEff, fromBot_r, pTop_r});
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked bits changed");
  property p_onetime;
    @(posedge ref_clk) disable iff (rst || cellInit)
      (pTop_r || bpVol_r || fromBot_r) |=>
      (({pTop_r, bpVol_r, fromBot_r} & $past({pTop_r, bpVol_r, fromBot_r}))
       == $past({pTop_r, bpVol_r, fromBot_r}));
  endproperty
  a_onetime: assert property (p_onetime)
    else $error("one-time bit returned to zero");
  property p_top1;
    @(posedge ref_clk) disable iff (rst)
      (bpEff == 3'h1 && !fromBot_r) |-> (pi.hit == (sector == 6'h3F));
  endproperty
  a_top1: assert property (p_top1)
    else $error("top-down decode wrong");
  property p_bot6;
    @(posedge ref_clk) disable iff (rst)
      (bpEff == 3'h6 && fromBot_r) |-> (pi.hit == !sector[5]);
  endproperty
  a_bot6: assert property (p_bot6)
    else $error("bottom-up decode wrong");
  property p_nohit;
    @(posedge ref_clk) disable iff (rst)
      opStart_r && opKind_r != KIND_OTP && opKind_r != KIND_REG && opKind_r != KIND_BULK
      |-> !$past(pi.hit);
  endproperty
  a_nohit: assert property (p_nohit)
    else $error("protected sector modified");
  property p_wel;
    @(posedge ref_clk) disable iff (rst) opStart_r |-> $past(wel_r) && $past(mod_r) == 3'h0;
  endproperty
  a_wel: assert property (p_wel)
    else $error("operation without latch or whole bytes");
  property p_welclr;
    @(posedge ref_clk) disable iff (rst) $fell(wip_r) |-> !wel_r;
  endproperty
  a_welclr: assert property (p_welclr)
    else $error("latch kept after completion");
endmodule : fwpc_top
`default_nettype wire

// *** rtl/fwpc_pkg.sv ***
/*
  Shared constants and types of the flash protection control block.
  Assumes one 25 MHz clock; opcodes and operation time are local choices.
*/
package fwpc_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // stand-in length of every program, erase or register write
  localparam int OP_TIME_NS = 10000;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = 9;
  localparam logic [BUSY_W-1:0] OP_LAST = BUSY_W'(OP_CYCLES - 1);
  localparam int ADDR_W = 22;
  localparam int KIND_W = 3;
  localparam int SECT_MSB = 21;
  localparam int SECT_LSB = 16;
  localparam logic [6:0] SECTOR_COUNT = 7'h40;
  localparam logic [5:0] PARAM_BOT_LAST = 6'h01;
  localparam logic [5:0] PARAM_TOP_FIRST = 6'h3E;
  localparam logic [2:0] BP_NONE = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [2:0] BP_VOL_RESET = 3'h7;
  localparam logic [5:0] CNT_OPCODE = 6'h08;
  localparam logic [5:0] CNT_STATUS = 6'h10;
  localparam logic [5:0] CNT_CONFIG = 6'h18;
  localparam logic [5:0] CNT_ADDR = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h28;
  localparam int SB_WIP = 0;
  localparam int SB_WEL = 1;
  localparam int SB_BP = 2;
  localparam int SB_EFAIL = 5;
  localparam int SB_PFAIL = 6;
  localparam int SB_STATUS_WRITE_DISABLE = 7;
  localparam int CB_LOCK = 0;
  localparam int CB_QUAD = 1;
  localparam int CB_PTOP = 2;
  localparam int CB_BPVOL = 3;
  localparam int CB_FROMBOT = 5;
  localparam logic NV_FLAG_INIT = 1'b0;
  localparam logic [2:0] NV_BP_INIT = 3'h0;
  localparam logic [3:0] PIN_INIT = 4'h5;
  localparam logic [7:0] CMD_WRITE_ENABLE_CMD = 8'hA1;
  localparam logic [7:0] CMD_WRITE_DISABLE_CMD = 8'hA2;
  localparam logic [7:0] CMD_RDSR = 8'hA3;
  localparam logic [7:0] CMD_RDCR = 8'hA4;
  localparam logic [7:0] CMD_REGW = 8'hA5;
  localparam logic [7:0] CMD_PROG = 8'hB1;
  localparam logic [7:0] CMD_QPROG = 8'hB2;
  localparam logic [7:0] CMD_OTP = 8'hB3;
  localparam logic [7:0] CMD_E64 = 8'hC1;
  localparam logic [7:0] CMD_E4 = 8'hC2;
  localparam logic [7:0] CMD_E8 = 8'hC3;
  localparam logic [7:0] CMD_BULK = 8'hC4;
  localparam logic [7:0] CMD_DEEP = 8'hD1;
  localparam logic [7:0] CMD_WAKE = 8'hD2;
  localparam logic [2:0] KIND_PROG = 3'h0;
  localparam logic [2:0] KIND_OTP = 3'h1;
  localparam logic [2:0] KIND_E64 = 3'h2;
  localparam logic [2:0] KIND_E4 = 3'h3;
  localparam logic [2:0] KIND_E8 = 3'h4;
  localparam logic [2:0] KIND_BULK = 3'h5;
  localparam logic [2:0] KIND_REG = 3'h6;
  typedef enum logic [1:0] {S_READY, S_BUSY, S_DEEP} fwpc_state_e;
endpackage : fwpc_pkg

// *** rtl/fwpc_prot_if.sv ***
/*
  Bundle between the control logic and the protected-range decoder.
  Assumes the user side drives code, direction and sector.
*/
`timescale 1ns/1ns
`default_nettype none
interface fwpc_prot_if;
  logic [2:0] bp;
  logic fromBottom;
  logic [5:0] sector;
  logic hit;
  modport dec (input bp, input fromBottom, input sector, output hit);
  modport user (output bp, output fromBottom, output sector, input hit);
endinterface : fwpc_prot_if
`default_nettype wire

// *** rtl/fwpc_sync.sv ***
/*
  Two-flop synchroniser for pins from outside the ref_clk domain.
  Assumes inputs are plain levels; no glitch filtering.
*/
`timescale 1ns/1ns
`default_nettype none
module fwpc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r, meta_nxt, q_r, q_nxt;

  always_comb begin
    meta_nxt = d;
    // the first stage is read by the second one only
    q_nxt = meta_r;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= INIT;
      q_r <= INIT;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : fwpc_sync
`default_nettype wire

// *** rtl/fwpc_range.sv ***
/*
  Decodes the block-protect code into a protected 64 KB sector range.
  Assumes a 64-sector array; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module fwpc_range (
  fwpc_prot_if.dec pi
);
  import fwpc_pkg::*;
  logic [6:0] span;

  always_comb begin
    // codes 1..6 cover 1, 2, 4 ... 32 sectors
    span = 7'h01 << (pi.bp - 3'h1);
    if (pi.bp == BP_NONE) begin
      pi.hit = 1'b0;
    end else if (pi.bp == BP_ALL) begin
      pi.hit = 1'b1;
    end else if (pi.fromBottom) begin
      pi.hit = {1'b0, pi.sector} < span;
    end else begin
      pi.hit = {1'b0, pi.sector} >= (SECTOR_COUNT - span);
    end
  end
endmodule : fwpc_range
`default_nettype wire

// *** testbench/fwpc_spi_host.sv ***
/*
  SPI bus master model, mode 0, for the flash protection control block.
  Assumes the bench calls its task from one process at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module fwpc_spi_host (
  input wire logic ref_clk,
  output logic sck,
  output logic csN,
  output logic si,
  input wire logic so,
  input wire logic soOe
);
  logic [7:0] rx;
  initial begin
    sck <= 1'b0;
    csN <= 1'b1;
    si <= 1'b0;
    rx = 8'h00;
  end
  // 320 ns link clock, eight ref_clk cycles, runs only inside a frame
  task automatic xfer(input logic [39:0] d, input int n);
    @(posedge ref_clk);
    csN <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si <= d[i];
      repeat (4) @(posedge ref_clk);
      sck <= 1'b1;
      // an undriven line shows the inverse, so a missing enable cannot pass
      rx = {rx[6:0], soOe ? so : ~so};
      repeat (4) @(posedge ref_clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    csN <= 1'b1;
    // a released line must not look like held data
    si <= ~si;
    repeat (10) @(posedge ref_clk);
  endtask : xfer
endmodule : fwpc_spi_host
`default_nettype wire

// *** testbench/fwpc_top_tb_top.sv ***
/*
  Self-checking bench of the flash protection control block.
  Assumes the SPI host model and the package opcodes and bit positions.
*/
`timescale 1ns/1ns
`default_nettype none
module fwpc_top_tb_top;
  import fwpc_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic write_enable_cmd;
    logic start;
    logic [2:0] kind;
  } fwpc_row_s;
  localparam fwpc_row_s ROWS [9] = '{
    '{CMD_PROG, 24'h100000, 1'b1, 1'b1, KIND_PROG},
    '{CMD_QPROG, 24'h200000, 1'b1, 1'b1, KIND_PROG},
    '{CMD_OTP, 24'h000000, 1'b1, 1'b1, KIND_OTP},
    '{CMD_E64, 24'h050000, 1'b1, 1'b1, KIND_E64},
    '{CMD_E4, 24'h000000, 1'b1, 1'b1, KIND_E4},
    '{CMD_E8, 24'h010000, 1'b1, 1'b1, KIND_E8},
    '{CMD_BULK, 24'h000000, 1'b1, 1'b1, KIND_BULK},
    '{CMD_PROG, 24'h100000, 1'b0, 1'b0, KIND_PROG},
    '{CMD_E4, 24'h200000, 1'b1, 1'b0, KIND_E4}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cellInit = 1'b0;
  logic wpN = 1'b1;
  logic sck, csN, si, so, soOe, powerActive, deepPowerDown, writeInProgress, opStart;
  logic [KIND_W-1:0] opKind;
  logic [ADDR_W-1:0] opAddr;
  int errorCnt = 0;
  int nChecks = 0;
  int starts = 0;
  int wipRun = 0;
  int lastRun = 0;
  int s0, n, pin, pout;

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (opStart === 1'b1) starts++;
    if (writeInProgress === 1'b1) wipRun++;
    else if (wipRun != 0) begin
      lastRun = wipRun;
      wipRun = 0;
    end
  end

  fwpc_spi_host i_fwpc_spi_host (.ref_clk(ref_clk), .sck(sck), .csN(csN), .si(si), .so(so),
    .soOe(soOe));
  fwpc_top i_fwpc_top (.ref_clk(ref_clk), .rst(rst), .cellInit(cellInit), .sck(sck),
    .csN(csN), .si(si), .wpN(wpN), .so(so), .soOe(soOe), .powerActive(powerActive),
    .deepPowerDown(deepPowerDown), .writeInProgress(writeInProgress), .opStart(opStart),
    .opKind(opKind), .opAddr(opAddr));

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic do_reset(input logic seed);
    rst <= 1'b1;
    cellInit <= seed;
    @(posedge ref_clk);
    cellInit <= 1'b0;
    repeat (9) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : do_reset

  task automatic rdchk(input string w, input logic [7:0] op, input logic [7:0] m,
                       input logic [7:0] e);
    i_fwpc_spi_host.xfer({24'h0, op, 8'h00}, 16);
    chk(w, e, i_fwpc_spi_host.rx & m);
    chk("soOe released", 1'b0, soOe);
  endtask : rdchk

  task automatic wait_idle();
    for (int i = 0; i < 400 && writeInProgress !== 1'b0; i++) @(posedge ref_clk);
    // let the busy monitor close its count first
    repeat (2) @(posedge ref_clk);
    #1;
    chk("idle", 1'b0, writeInProgress);
  endtask : wait_idle

  task automatic do_op(input logic [7:0] op, input logic [23:0] a, input logic write_enable_cmd,
                       input logic start, input logic [2:0] kind);
    int s;
    if (write_enable_cmd) i_fwpc_spi_host.xfer({32'h0, CMD_WRITE_ENABLE_CMD}, 8);
    s = starts;
    i_fwpc_spi_host.xfer({8'h0, op, a}, 32);
    chk("opStart", start, starts - s);
    if (start) begin
      chk("opKind", kind, opKind);
      chk("opAddr", a[21:0], opAddr);
      chk("active", 1'b1, powerActive);
      wait_idle();
      chk("busy cycles", OP_CYCLES, lastRun);
      chk("standby", 1'b0, powerActive);
    end
  endtask : do_op

  task automatic register_write_cmd(input logic [7:0] st, input logic [7:0] cf);
    i_fwpc_spi_host.xfer({32'h0, CMD_WRITE_ENABLE_CMD}, 8);
    i_fwpc_spi_host.xfer({16'h0, CMD_REGW, st, cf}, 24);
    wait_idle();
  endtask : register_write_cmd

  initial begin
    // about twice the expected length of all tests
    #2500000;
    errorCnt++;
    complete_run();
  end

  initial begin
    do_reset(1'b1);
    chk("reset outs", 5'h00, {powerActive, deepPowerDown, writeInProgress, soOe, opStart});
    rdchk("status", CMD_RDSR, 8'hFF, 8'h00);
    rdchk("config", CMD_RDCR, 8'hFF, 8'h00);
    $display("test reset done");
    foreach (ROWS[i]) begin
      do_op(ROWS[i].op, ROWS[i].addr, ROWS[i].write_enable_cmd, ROWS[i].start, ROWS[i].kind);
      rdchk("latch", CMD_RDSR, 8'h03, {6'h0, ROWS[i].write_enable_cmd & ~ROWS[i].start, 1'b0});
    end
    $display("test command table done");
    rdchk("erase fail", CMD_RDSR, 8'h20, 8'h20);
    i_fwpc_spi_host.xfer({32'h0, CMD_WRITE_DISABLE_CMD}, 8);
    rdchk("latch off", CMD_RDSR, 8'h02, 8'h00);
    i_fwpc_spi_host.xfer({32'h0, CMD_WRITE_ENABLE_CMD}, 8);
    s0 = starts;
    i_fwpc_spi_host.xfer({7'h0, CMD_PROG, 24'h100000, 1'b0}, 33);
    chk("odd count", 32'h0, starts - s0);
    i_fwpc_spi_host.xfer({32'h0, CMD_DEEP}, 8);
    chk("deep", 1'b1, deepPowerDown);
    do_op(CMD_PROG, 24'h100000, 1'b1, 1'b0, KIND_PROG);
    i_fwpc_spi_host.xfer({32'h0, CMD_WAKE}, 8);
    chk("wake", 1'b0, deepPowerDown);
    $display("test refusals done");
    // d = 0 grows down from the top, d = 1 up from zero with parameters on top
    for (int d = 0; d < 2; d++) begin
      for (int c = 1; c < 8; c++) begin
        register_write_cmd({3'h0, c[2:0], 2'h0}, {2'h0, d[0], 2'h0, d[0], 2'h0});
        n = (c == 7) ? 64 : (1 << (c - 1));
        pin = (d == 1) ? n - 1 : 64 - n;
        pout = (d == 1) ? n : 63 - n;
        do_op(CMD_PROG, {2'h0, pin[5:0], d[0] ? 16'hFFFF : 16'h0000}, 1'b1, 1'b0,
              KIND_PROG);
        if (c < 7) do_op(CMD_PROG, {2'h0, pout[5:0], d[0] ? 16'h0000 : 16'hFFFF}, 1'b1,
                         1'b1, KIND_PROG);
      end
    end
    register_write_cmd(8'h00, 8'h00);
    rdchk("one-time bits", CMD_RDCR, 8'hFF, 8'h24);
    // parameter sectors now sit at the top
    do_op(CMD_E4, 24'h3F0000, 1'b1, 1'b1, KIND_E4);
    do_op(CMD_E8, 24'h000000, 1'b1, 1'b0, KIND_E8);
    $display("test ranges done");
    register_write_cmd(8'h04, 8'h25);
    register_write_cmd(8'h00, 8'h24);
    rdchk("locked bp", CMD_RDSR, 8'h1C, 8'h04);
    rdchk("locked cfg", CMD_RDCR, 8'hFF, 8'h25);
    do_reset(1'b0);
    rdchk("lock cleared", CMD_RDCR, 8'hFF, 8'h24);
    rdchk("bp kept", CMD_RDSR, 8'h1C, 8'h04);
    register_write_cmd(8'h84, 8'h24);
    @(posedge ref_clk) wpN <= 1'b0;
    register_write_cmd(8'h08, 8'h24);
    rdchk("hw protect", CMD_RDSR, 8'h9C, 8'h84);
    // sector 0 is protected from the bottom while the pin is low
    do_op(CMD_PROG, 24'h000000, 1'b1, 1'b0, KIND_PROG);
    register_write_cmd(8'h84, 8'h26);
    register_write_cmd(8'h08, 8'h26);
    rdchk("quad pin", CMD_RDSR, 8'h9C, 8'h08);
    @(posedge ref_clk) wpN <= 1'b1;
    register_write_cmd(8'h00, 8'h2C);
    do_reset(1'b0);
    rdchk("volatile bp", CMD_RDSR, 8'h1C, 8'h1C);
    do_op(CMD_BULK, 24'h000000, 1'b1, 1'b0, KIND_BULK);
    rdchk("bulk fail", CMD_RDSR, 8'h20, 8'h20);
    $display("test protection bits done");
    complete_run();
  end
endmodule : fwpc_top_tb_top
`default_nettype wire
